/* common/ccr_params.svh */
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

`define CCR_AW 12
`define CCR_DW 32

`define CCR_OFF_DIV16 12'h020
`define CCR_OFF_SEL16 12'h024
`define CCR_OFF_DIV30 12'h028
`define CCR_OFF_DIV19 12'h02c
`define CCR_OFF_DIV21 12'h034
`define CCR_OFF_SEL21 12'h038
`define CCR_OFF_ORIGIN 12'h03c
`define CCR_OFF_GATE1 12'h040
`define CCR_OFF_GATE2 12'h044
`define CCR_OFF_GATE8Q 12'h048
`define CCR_OFF_GATE8S 12'h04c
`define CCR_OFF_GATE10 12'h050
`define CCR_OFF_GATE11 12'h054
`define CCR_OFF_GATEDBG 12'h05c
`define CCR_OFF_GATE16 12'h064
`define CCR_OFF_GATE19 12'h06c
`define CCR_OFF_GATE21 12'h070
`define CCR_OFF_SWRST 12'h080
`define CCR_OFF_KEEPRUN 12'h104

`define CCR_DIV_EN_BIT 9
`define CCR_RATIO_MSB 8
`define CCR_RATIO_RST 9'h00e
`define CCR_RATIO_D30_EFF 9'h01e
`define CCR_RATIO_MAX 9'h1fe
`define CCR_SEL_FAST 2'b00
`define CCR_SEL_SLOW 2'b01

`define CCR_G1_RST 10'h291
`define CCR_G1_RO_MASK 10'h001
`define CCR_G2_RST 3'h5
`define CCR_G8Q_RST 1'b0
`define CCR_G8S_RST 4'h0
`define CCR_G10_RST 7'h43
`define CCR_G10_RO_MASK 7'h01
`define CCR_G11_RST 1'b0
`define CCR_GDBG_RST 1'b1
`define CCR_GDOM_RST 1'b0
`define CCR_SWRST_RST 7'h00
`define CCR_SWRST_USED 6

`endif

/* common/ccr_pkg.sv */
package ccr_pkg;

  typedef struct packed {
    logic en;
    logic [8:0] ratio;
  } ccr_div_t;

  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
    logic level;
  } ccr_dstate_t;

  typedef struct packed {
    ccr_div_t div16;
    ccr_div_t div30;
    ccr_div_t div19;
    ccr_div_t div21;
    logic div30_untouched;
    logic [1:0] sel16;
    logic [1:0] sel21;
    logic stop16;
    logic stop21;
    logic origin;
    logic origin_done;
    logic [9:0] g1;
    logic [2:0] g2;
    logic g8q;
    logic [3:0] g8s;
    logic [6:0] g10;
    logic g11;
    logic gdbg;
    logic g16;
    logic g19;
    logic g21;
    logic [6:0] swrst;
    logic keep_running;
    logic [31:0] rdata;
  } ccr_regs_t;

endpackage : ccr_pkg

/* hw/ccr_clk_ctrl.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "ccr_params.svh"

// Contract
// - Divider enable bit 9 set divides; clear bypasses source straight through.
// - Ratio bits 8:0 divide by value plus two; 0x1FE gives 512.
// - Domains 16, 19, 21 ratios reset to 0xE, enables to 1.
// - Domain 30 ratio reads 0x0E after reset but divides by 32 until written.
// - Source select 00 picks fast/divided clock, 01 the 32 kHz; resets 00.
// - Reserved select code stops that clock until system reset.
// - Read-only bit 0 shows fast clock origin, oscillator 0, pad 1.
// - Each path gate bit: 0 stops its clock or, for domains 16, 19, 21, only the enable tick; 1 runs it.
// - Domain-1 gates bits 9..0; 9,7,4,0 reset 1; bit 0 read-only one.
// - Domain-2 gates: fuse bit 2, fabric bit 1, config bit 0; 2,0 reset 1.
// - Domain-8 quad gate bit 0, single gates bits 3..0, all reset 0.
// - Domain-10 gates bits 6..0; 6,1,0 reset 1; bit 0 read-only one.
// - Debug pin gate resets 1; domain 16, 19, 21 gates reset 0.
// - Writing 1 to a soft reset bit asserts it at once.
// - Writing 0 releases the soft reset on the clock edge, gated or not.
// - Fabric soft reset bits 0..5 map FIFOs and peripheral, reset 0.
// - Fabric soft reset bit 6 is plain storage, resets 0.
// - Domain-0 serial clock stops while chip select idle unless keep-running.

module ccr_clk_ctrl
  import ccr_pkg::*;
#(
  parameter logic PAD_ORIGIN_SUPPORTED = 1'b0
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic slow_clk_tick,
  input wire logic boot_pad_strap,
  input wire logic serial_cs_active,
  output logic clk16_en,
  output logic clk16_level,
  output logic clk19_en,
  output logic clk19_level,
  output logic clk21_en,
  output logic clk21_level,
  output logic clk30_en,
  output logic clk30_level,
  output logic [9:0] clk1_path_en,
  output logic [2:0] clk2_path_en,
  output logic clk8_quad_path_en,
  output logic [3:0] clk8_single_path_en,
  output logic [6:0] clk10_path_en,
  output logic clk11_path_en,
  output logic debug_pin_clk_en,
  output logic domain_zero_clock_en,
  output logic fifo_zero_soft_reset,
  output logic fifo_one_soft_reset,
  output logic fifo_two_soft_reset,
  output logic big_fifo_soft_reset,
  output logic async_fifo_soft_reset,
  output logic fabric_peripheral_soft_reset
);

  ccr_regs_t q;
  ccr_regs_t d;
  logic tick16;
  logic tick19;
  logic tick21;
  logic tick30;
  logic [8:0] ratio30_eff;
  logic wr_swrst;
  logic [6:0] swrst_now;

  // ****************************************
  // Helpers.
  // ****************************************
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic ccr_div_t div_field(input logic [31:0] w);
    div_field.en = w[`CCR_DIV_EN_BIT];
    div_field.ratio = w[`CCR_RATIO_MSB:0];
  endfunction : div_field

  function automatic logic [31:0] div_read(input ccr_div_t v);
    div_read = {22'h000000, v.en, v.ratio};
  endfunction : div_read

  function automatic logic sel_reserved(input logic [1:0] s);
    sel_reserved = (s != `CCR_SEL_FAST) && (s != `CCR_SEL_SLOW);
  endfunction : sel_reserved

  // ****************************************
  // Register file.
  // ****************************************
  always_comb
  begin
    d = q;
    if (reg_wr)
    begin
      if (hit(reg_addr, `CCR_OFF_DIV16))
      begin
        d.div16 = div_field(reg_wdata);
      end
      if (hit(reg_addr, `CCR_OFF_DIV30))
      begin
        d.div30 = div_field(reg_wdata);
        d.div30_untouched = 1'b0;
      end
      if (hit(reg_addr, `CCR_OFF_DIV19))
      begin
        d.div19 = div_field(reg_wdata);
      end
      if (hit(reg_addr, `CCR_OFF_DIV21))
      begin
        d.div21 = div_field(reg_wdata);
      end
      if (hit(reg_addr, `CCR_OFF_SEL16))
      begin
        d.sel16 = reg_wdata[1:0];
      end
      if (hit(reg_addr, `CCR_OFF_SEL21))
      begin
        d.sel21 = reg_wdata[1:0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE1))
      begin
        // Bit 0 always runs and cannot be written.
        d.g1 = reg_wdata[9:0] | `CCR_G1_RO_MASK;
      end
      if (hit(reg_addr, `CCR_OFF_GATE2))
      begin
        d.g2 = reg_wdata[2:0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE8Q))
      begin
        d.g8q = reg_wdata[0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE8S))
      begin
        d.g8s = reg_wdata[3:0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE10))
      begin
        d.g10 = reg_wdata[6:0] | `CCR_G10_RO_MASK;
      end
      if (hit(reg_addr, `CCR_OFF_GATE11))
      begin
        // The enabling bit elsewhere is software's business.
        d.g11 = reg_wdata[0];
      end
      if (hit(reg_addr, `CCR_OFF_GATEDBG))
      begin
        d.gdbg = reg_wdata[0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE16))
      begin
        d.g16 = reg_wdata[0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE19))
      begin
        d.g19 = reg_wdata[0];
      end
      if (hit(reg_addr, `CCR_OFF_GATE21))
      begin
        d.g21 = reg_wdata[0];
      end
      if (hit(reg_addr, `CCR_OFF_SWRST))
      begin
        // Bits hold until software writes them back to zero.
        d.swrst = reg_wdata[6:0];
      end
      if (hit(reg_addr, `CCR_OFF_KEEPRUN))
      begin
        d.keep_running = reg_wdata[0];
      end
    end
    // A reserved select code latches a stop that only reset clears.
    if (sel_reserved(d.sel16))
    begin
      d.stop16 = 1'b1;
    end
    if (sel_reserved(d.sel21))
    begin
      d.stop21 = 1'b1;
    end
    // The strap is caught once, in the first cycle after reset release.
    if (!q.origin_done)
    begin
      d.origin = boot_pad_strap & PAD_ORIGIN_SUPPORTED;
      d.origin_done = 1'b1;
    end
    d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `CCR_OFF_DIV16: d.rdata = div_read(q.div16);
        `CCR_OFF_DIV30: d.rdata = div_read(q.div30);
        `CCR_OFF_DIV19: d.rdata = div_read(q.div19);
        `CCR_OFF_DIV21: d.rdata = div_read(q.div21);
        `CCR_OFF_SEL16: d.rdata = {30'h00000000, q.sel16};
        `CCR_OFF_SEL21: d.rdata = {30'h00000000, q.sel21};
        `CCR_OFF_ORIGIN: d.rdata = {31'h00000000, q.origin};
        `CCR_OFF_GATE1: d.rdata = {22'h000000, q.g1};
        `CCR_OFF_GATE2: d.rdata = {29'h00000000, q.g2};
        `CCR_OFF_GATE8Q: d.rdata = {31'h00000000, q.g8q};
        `CCR_OFF_GATE8S: d.rdata = {28'h0000000, q.g8s};
        `CCR_OFF_GATE10: d.rdata = {25'h0000000, q.g10};
        `CCR_OFF_GATE11: d.rdata = {31'h00000000, q.g11};
        `CCR_OFF_GATEDBG: d.rdata = {31'h00000000, q.gdbg};
        `CCR_OFF_GATE16: d.rdata = {31'h00000000, q.g16};
        `CCR_OFF_GATE19: d.rdata = {31'h00000000, q.g19};
        `CCR_OFF_GATE21: d.rdata = {31'h00000000, q.g21};
        `CCR_OFF_SWRST: d.rdata = {25'h0000000, q.swrst};
        `CCR_OFF_KEEPRUN: d.rdata = {31'h00000000, q.keep_running};
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.div16 <= '{en: 1'b1, ratio: `CCR_RATIO_RST};
      q.div19 <= '{en: 1'b1, ratio: `CCR_RATIO_RST};
      q.div21 <= '{en: 1'b1, ratio: `CCR_RATIO_RST};
      q.div30 <= '{en: 1'b1, ratio: `CCR_RATIO_RST};
      q.div30_untouched <= 1'b1;
      q.sel16 <= `CCR_SEL_FAST;
      q.sel21 <= `CCR_SEL_FAST;
      q.g1 <= `CCR_G1_RST;
      q.g2 <= `CCR_G2_RST;
      q.g8q <= `CCR_G8Q_RST;
      q.g8s <= `CCR_G8S_RST;
      q.g10 <= `CCR_G10_RST;
      q.g11 <= `CCR_G11_RST;
      q.gdbg <= `CCR_GDBG_RST;
      q.g16 <= `CCR_GDOM_RST;
      q.g19 <= `CCR_GDOM_RST;
      q.g21 <= `CCR_GDOM_RST;
      q.swrst <= `CCR_SWRST_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;

  // ****************************************
  // Dividers.
  // ****************************************
  // The untouched domain-30 reset value divides by 32, not by 16.
  assign ratio30_eff = q.div30_untouched ? `CCR_RATIO_D30_EFF : q.div30.ratio;

  ccr_clk_div u_div16 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(~q.stop16),
    .div_on(q.div16.en),
    .ratio(q.div16.ratio),
    .slow_sel(q.sel16 == `CCR_SEL_SLOW),
    .slow_tick(slow_clk_tick),
    .clk_tick(tick16),
    .clk_level(clk16_level)
  );

  ccr_clk_div u_div19 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(1'b1),
    .div_on(q.div19.en),
    .ratio(q.div19.ratio),
    .slow_sel(1'b0),
    .slow_tick(slow_clk_tick),
    .clk_tick(tick19),
    .clk_level(clk19_level)
  );

  ccr_clk_div u_div21 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(~q.stop21),
    .div_on(q.div21.en),
    .ratio(q.div21.ratio),
    .slow_sel(q.sel21 == `CCR_SEL_SLOW),
    .slow_tick(slow_clk_tick),
    .clk_tick(tick21),
    .clk_level(clk21_level)
  );

  ccr_clk_div u_div30 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(1'b1),
    .div_on(q.div30.en),
    .ratio(ratio30_eff),
    .slow_sel(1'b0),
    .slow_tick(slow_clk_tick),
    .clk_tick(tick30),
    .clk_level(clk30_level)
  );

  // ****************************************
  // Path gates.
  // ****************************************
  assign clk16_en = tick16 & q.g16;
  assign clk19_en = tick19 & q.g19;
  assign clk21_en = tick21 & q.g21;
  assign clk30_en = tick30;
  assign clk1_path_en = q.g1;
  assign clk2_path_en = q.g2;
  assign clk8_quad_path_en = q.g8q;
  assign clk8_single_path_en = q.g8s;
  assign clk10_path_en = q.g10;
  assign clk11_path_en = q.g11;
  assign debug_pin_clk_en = q.gdbg;
  assign domain_zero_clock_en = serial_cs_active | q.keep_running;

  // ****************************************
  // Soft resets.
  // ****************************************
  // A written one shows in the write cycle itself; a written zero only
  // takes effect at the edge, so release is synchronous to core_clk,
  // which keeps running while the target clock is gated.
  assign wr_swrst = reg_wr & hit(reg_addr, `CCR_OFF_SWRST);
  assign swrst_now = q.swrst | (wr_swrst ? reg_wdata[6:0] : 7'h00);
  assign fifo_zero_soft_reset = swrst_now[0];
  assign fifo_one_soft_reset = swrst_now[1];
  assign fifo_two_soft_reset = swrst_now[2];
  assign big_fifo_soft_reset = swrst_now[3];
  assign async_fifo_soft_reset = swrst_now[4];
  assign fabric_peripheral_soft_reset = swrst_now[5];

endmodule : ccr_clk_ctrl

/* hw/ccr_clk_div.sv */
`timescale 1ns/1ps
`include "ccr_params.svh"

module ccr_clk_div
  import ccr_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic div_on,
  input wire logic [8:0] ratio,
  input wire logic slow_sel,
  input wire logic slow_tick,
  output logic clk_tick,
  output logic clk_level
);

  ccr_dstate_t q;
  ccr_dstate_t d;
  logic [8:0] ratio_c;
  logic [8:0] last;
  logic [9:0] half;

  // ****************************************
  // Divide by ratio plus two, or bypass.
  // ****************************************
  always_comb
  begin
    d = q;
    // The reserved top code is clamped to the largest legal ratio.
    ratio_c = (ratio > `CCR_RATIO_MAX) ? `CCR_RATIO_MAX : ratio;
    last = ratio_c + 9'h001;
    half = ({1'b0, ratio_c} + 10'h002) >> 1;
    if (!run)
    begin
      d.cnt = 9'h000;
      d.tick = 1'b0;
      d.level = 1'b0;
    end
    else if (slow_sel)
    begin
      d.cnt = 9'h000;
      d.tick = slow_tick;
      d.level = q.level ^ slow_tick;
    end
    else if (!div_on)
    begin
      d.cnt = 9'h000;
      d.tick = 1'b1;
      d.level = ~q.level;
    end
    else
    begin
      d.cnt = (q.cnt >= last) ? 9'h000 : q.cnt + 9'h001;
      d.tick = (q.cnt >= last);
      d.level = ({1'b0, d.cnt} < half);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign clk_tick = q.tick;
  assign clk_level = q.level;

endmodule : ccr_clk_div

/* tb/ccr_clk_ctrl_properties.sv */
`timescale 1ns/1ps
// ********
// Register port and output checks.
// ********
module ccr_clk_ctrl_properties (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic serial_cs_active,
  input wire logic clk16_en,
  input wire logic [9:0] clk1_path_en,
  input wire logic [2:0] clk2_path_en,
  input wire logic [6:0] clk10_path_en,
  input wire logic clk11_path_en,
  input wire logic domain_zero_clock_en,
  input wire logic fifo_zero_soft_reset,
  input wire logic fabric_peripheral_soft_reset
);
  logic w80;
  logic w40;
  logic w44;
  logic w54;
  logic w64;
  logic rel5;
  assign w80 = reg_wr && reg_addr == 12'h080;
  assign w40 = reg_wr && reg_addr == 12'h040;
  assign w44 = reg_wr && reg_addr == 12'h044;
  assign w54 = reg_wr && reg_addr == 12'h054;
  assign w64 = reg_wr && reg_addr == 12'h064;
  assign rel5 = w80 && !reg_wdata[5];
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_origin_osc: assert property (reg_rd && reg_addr == 12'h03c |=> reg_rdata == 32'h0)
    else $error("clock origin status not zero");
  a_soft_now: assert property (w80 && reg_wdata[0] |-> fifo_zero_soft_reset)
    else $error("soft reset not asserted in the write cycle");
  a_soft_sticky: assert property (fifo_zero_soft_reset && !w80 |=> fifo_zero_soft_reset)
    else $error("soft reset cleared by itself");
  a_soft_release: assert property (rel5 ##1 !w80 |-> !fabric_peripheral_soft_reset)
    else $error("soft reset not released after writing zero");
  a_gate_fixed: assert property (clk1_path_en[0] && clk10_path_en[0])
    else $error("fixed clock path stopped");
  a_gate1_write: assert property (w40 |=> clk1_path_en[9:1] == $past(reg_wdata[9:1]))
    else $error("domain 1 gates do not follow write");
  a_gate2_write: assert property (w44 |=> clk2_path_en == $past(reg_wdata[2:0]))
    else $error("domain 2 gates do not follow write");
  a_gate11_write: assert property (w54 |=> clk11_path_en == $past(reg_wdata[0]))
    else $error("domain 11 gate does not follow write");
  a_gate16_stop: assert property (w64 && !reg_wdata[0] |=> !clk16_en)
    else $error("domain 16 clock runs with gate off");
  a_cs_clock: assert property (serial_cs_active |-> domain_zero_clock_en)
    else $error("serial clock gated while selected");
endmodule : ccr_clk_ctrl_properties

/* tb/testbench.sv */
`timescale 1ns/1ps
// ********
// Register level scenarios.
// ********
module testbench;
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow_clk_tick = 1'b0;
  logic boot_pad_strap = 1'b1, serial_cs_active = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic clk16_en, clk16_level, clk19_en, clk19_level, clk21_en, clk21_level, clk30_en, clk30_level;
  logic [9:0] clk1_path_en;
  logic [2:0] clk2_path_en;
  logic clk8_quad_path_en, clk11_path_en, debug_pin_clk_en, domain_zero_clock_en;
  logic [3:0] clk8_single_path_en;
  logic [6:0] clk10_path_en;
  logic fifo_zero_soft_reset, fifo_one_soft_reset, fifo_two_soft_reset, big_fifo_soft_reset;
  logic async_fifo_soft_reset, fabric_peripheral_soft_reset;
  logic [3:0] tk;
  logic [3:0] lv;
  logic [5:0] srst;
  int fails = 0, samples_checked = 0, sc = 0;
  logic [11:0] adr [19] = '{12'h020, 12'h024, 12'h028, 12'h02c, 12'h034, 12'h038, 12'h03c,
    12'h040, 12'h044, 12'h048, 12'h04c, 12'h050, 12'h054, 12'h05c, 12'h064, 12'h06c, 12'h070,
    12'h080, 12'h0f0};
  logic [9:0] rst_val [19] = '{10'h20e, 10'h0, 10'h20e, 10'h20e, 10'h20e, 10'h0, 10'h0, 10'h291,
    10'h5, 10'h0, 10'h0, 10'h43, 10'h0, 10'h1, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0};
  logic [9:0] msk [19] = '{10'h3ff, 10'h3, 10'h3ff, 10'h3ff, 10'h3ff, 10'h3, 10'h0, 10'h3fe,
    10'h7, 10'h1, 10'hf, 10'h7e, 10'h1, 10'h1, 10'h1, 10'h1, 10'h1, 10'h7f, 10'h0};
  assign tk = {clk30_en, clk21_en, clk19_en, clk16_en};
  assign lv = {clk30_level, clk21_level, clk19_level, clk16_level};
  assign srst = {fabric_peripheral_soft_reset, async_fifo_soft_reset, big_fifo_soft_reset,
    fifo_two_soft_reset, fifo_one_soft_reset, fifo_zero_soft_reset};
  always #2.5 core_clk = ~core_clk;
  // The slow clock ticks once every 40 core cycles.
  always @(posedge core_clk)
  begin
    sc <= (sc == 39) ? 0 : sc + 1;
    slow_clk_tick <= (sc == 39);
  end
  ccr_clk_ctrl u_ccr_clk_ctrl (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .slow_clk_tick, .boot_pad_strap, .serial_cs_active, .clk16_en, .clk16_level,
    .clk19_en, .clk19_level, .clk21_en, .clk21_level, .clk30_en, .clk30_level, .clk1_path_en,
    .clk2_path_en, .clk8_quad_path_en, .clk8_single_path_en, .clk10_path_en, .clk11_path_en,
    .debug_pin_clk_en, .domain_zero_clock_en, .fifo_zero_soft_reset, .fifo_one_soft_reset,
    .fifo_two_soft_reset, .big_fifo_soft_reset, .async_fifo_soft_reset,
    .fabric_peripheral_soft_reset);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, "read");
  endtask : rchk
  // Measures the spacing of the third tick to the second one.
  task automatic period(input int i, input int e);
    int n, t0, k;
    n = 0;
    k = 0;
    t0 = 0;
    while (k < 3 && n < 3000)
    begin
      @(posedge core_clk);
      #1 n++;
      if (tk[i] === 1'b1)
      begin
        k++;
        if (k == 2) t0 = n;
      end
    end
    chk(n - t0, e, "period");
  endtask : period
  task automatic none(input int i, input int len);
    int k;
    k = 0;
    repeat (len)
    begin
      @(posedge core_clk);
      #1 if (tk[i] !== 1'b0) k++;
    end
    chk(k, 0, "stopped clock ticks");
  endtask : none
  // Counts the cycles in which a divided clock level is high.
  task automatic duty(input int i, input int len, input int e);
    int k;
    k = 0;
    repeat (len)
    begin
      @(posedge core_clk);
      #1 if (lv[i] === 1'b1) k++;
    end
    chk(k, e, "duty");
  endtask : duty
  task automatic t_reset_vals;
    do_reset;
    foreach (adr[j])
    begin
      rchk(adr[j], rst_val[j]);
    end
    chk(clk1_path_en, 32'h291, "gate 1");
    chk({clk2_path_en, clk8_quad_path_en, clk8_single_path_en}, 32'ha0, "gates");
    chk({clk10_path_en, clk11_path_en}, 32'h86, "gate 10 11");
    chk({debug_pin_clk_en, srst}, 32'h40, "dbg soft");
    $display("test reset_vals done");
  endtask : t_reset_vals
  task automatic t_regs;
    logic [31:0] p;
    logic [31:0] want;
    do_reset;
    foreach (adr[j])
    begin
      p = 32'hffff_fffe;
      repeat (2)
      begin
        wr(adr[j], p);
        want = (p & msk[j]) | (adr[j] == 12'h040 || adr[j] == 12'h050);
        rchk(adr[j], want);
        p = 32'h1;
      end
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_divide;
    do_reset;
    wr(12'h064, 32'h1);
    wr(12'h06c, 32'h1);
    wr(12'h070, 32'h1);
    for (int i = 0; i < 4; i++) period(i, (i == 3) ? 32 : 16);
    for (int i = 0; i < 4; i++) duty(i, (i == 3) ? 32 : 16, (i == 3) ? 16 : 8);
    wr(12'h028, 32'h20e);
    period(3, 16);
    wr(12'h020, 32'h200);
    period(0, 2);
    wr(12'h020, 32'h3fe);
    period(0, 512);
    wr(12'h020, 32'h00e);
    period(0, 1);
    duty(0, 16, 8);
    wr(12'h064, 32'h0);
    none(0, 40);
    $display("test divide done");
  endtask : t_divide
  task automatic t_select;
    do_reset;
    wr(12'h064, 32'h1);
    wr(12'h024, 32'h1);
    period(0, 40);
    wr(12'h024, 32'h0);
    period(0, 16);
    wr(12'h070, 32'h1);
    wr(12'h038, 32'h2);
    none(2, 600);
    wr(12'h038, 32'h0);
    none(2, 600);
    do_reset;
    wr(12'h070, 32'h1);
    period(2, 16);
    $display("test select done");
  endtask : t_select
  task automatic t_soft;
    do_reset;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= 12'h080;
      reg_wdata <= 32'h1 << i;
      #1 chk(srst, (32'h1 << i) & 32'h3f, "soft set");
      @(posedge core_clk);
      reg_wr <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1 chk(srst, (32'h1 << i) & 32'h3f, "soft hold");
      rchk(12'h080, 32'h1 << i);
      wr(12'h080, 32'h0);
      #1 chk(srst, 32'h0, "soft release");
    end
    $display("test soft done");
  endtask : t_soft
  task automatic t_serial;
    do_reset;
    @(posedge core_clk) serial_cs_active <= 1'b1;
    #1 chk(domain_zero_clock_en, 1'b1, "cs on");
    @(posedge core_clk) serial_cs_active <= 1'b0;
    #1 chk(domain_zero_clock_en, 1'b0, "cs off");
    wr(12'h104, 32'h1);
    #1 chk(domain_zero_clock_en, 1'b1, "keep running");
    // The enabling bit in the separate miscellaneous register lives outside this block.
    wr(12'h054, 32'h1);
    #1 chk(clk11_path_en, 1'b1, "gate 11 on");
    wr(12'h05c, 32'h0);
    #1 chk(debug_pin_clk_en, 1'b0, "debug gate off");
    $display("test serial done");
  endtask : t_serial
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  initial
  begin
    #100_000;
    fails++;
    finish_test;
  end
  initial
  begin
    t_reset_vals;
    t_regs;
    t_divide;
    t_select;
    t_soft;
    t_serial;
    finish_test;
  end
endmodule : testbench
bind ccr_clk_ctrl ccr_clk_ctrl_properties u_props (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .serial_cs_active, .clk16_en, .clk1_path_en, .clk2_path_en,
  .clk10_path_en, .clk11_path_en, .domain_zero_clock_en, .fifo_zero_soft_reset,
  .fabric_peripheral_soft_reset);
